// [hdl/tws_pkg.sv]
// shared constants and types for the two-wire slave interface
package tws_pkg;

	// register byte offsets on the register bus
	localparam logic [7:0] OFS_ADDR = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0c;

	// reset values
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'hff;
	localparam logic [1:0] PRE_RST = 2'h0;

	// status register layout: code in [7:3], reserved [2], prescaler [1:0]
	localparam int STAT_CODE_LSB = 3;
	localparam int STAT_PRE_W = 2;

	// status codes
	localparam logic [7:0] SC_START = 8'h08;
	localparam logic [7:0] SC_SLA_W = 8'h60;
	localparam logic [7:0] SC_ARB_SLA_W = 8'h68;
	localparam logic [7:0] SC_GC = 8'h70;
	localparam logic [7:0] SC_ARB_GC = 8'h78;
	localparam logic [7:0] SC_RX_ACK = 8'h80;
	localparam logic [7:0] SC_RX_NACK = 8'h88;
	localparam logic [7:0] SC_GC_RX_ACK = 8'h90;
	localparam logic [7:0] SC_GC_RX_NACK = 8'h98;
	localparam logic [7:0] SC_STOP = 8'ha0;
	localparam logic [7:0] SC_SLA_R = 8'ha8;
	localparam logic [7:0] SC_ARB_SLA_R = 8'hb0;
	localparam logic [7:0] SC_TX_ACK = 8'hb8;
	localparam logic [7:0] SC_TX_NACK = 8'hc0;
	localparam logic [7:0] SC_TX_LAST_ACK = 8'hc8;
	localparam logic [7:0] SC_NONE = 8'hf8;

	localparam logic [6:0] GC_ADDR = 7'h00;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// timing
	localparam int CLK_MHZ = 200;
	localparam int START_HOLD_NS = 4000;
	localparam int START_HOLD_CYC = (START_HOLD_NS * CLK_MHZ + 999) / 1000;

	// control register fields, msb first
	typedef struct packed {
		logic interrupt_flag;
		logic acknowledge_enable;
		logic start_request;
		logic stop_request;
		logic write_collision_flag;
		logic interface_enable;
		logic reserved;
		logic interrupt_enable;
	} tws_ctrl_t;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_RX,
		ST_RX_ACK,
		ST_TX,
		ST_TX_ACK,
		ST_IGNORE,
		ST_MSTART
	} tws_state_t;

endpackage

// [hdl/tws_slave.sv]
// two-wire slave receiver/transmitter with apb register access
//
// Operation
// R1 - after 0x90 receive next general-call byte, ack per acknowledge_enable
// R2 - after 0x98 leave addressed slave operation
// R3 - stop or repeated start while addressed reports 0xA0, then not addressed
// R4 - start_request set in not addressed state sends START when bus free
// R5 - own address needs acknowledge_enable, general call also needs general_call_enable
// R6 - compare address against upper seven bits of own_slave_address
// R7 - general call 0x00 answered only when address lsb is one
// R8 - software enables interface and ack, clears start and stop requests
// R9 - direction bit one enters transmit, zero enters receive
// R10 - after address acknowledged set interrupt_flag with valid status
// R11 - lost arbitration then addressed for read reports 0xB0
// R12 - ack enable cleared sends last byte, then 0xC0 on NACK, 0xC8 on ACK
// R13 - after last byte release data and ignore master clocking
// R14 - acknowledge_enable zero ignores own address, keeps monitoring bus
// R15 - in deep sleep still acknowledge address and wake the part
// R16 - after wake match hold clock low until flag cleared by writing one
// R17 - data register content not updated during deep sleep
// R18 - software masks prescaler bits before reading status codes
// R19 - after 0xA8 transmit loaded byte, last if acknowledge_enable zero
// R20 - after 0xB8 transmit next loaded byte same way
// R21 - status reads 0xF8 whenever interrupt_flag is clear
// R22 - hold clock low while interrupt_flag set in slave states
//
// Register access over APB and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module tws_slave (
	// clock, reset, enable
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	// apb slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// serial clock line
	input wire logic SCL_IN,
	output logic SCL_OUT,
	output logic SCL_OE,
	// serial data line
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// power management
	input wire logic SLEEP_DEEP,
	output logic WAKE
);

	function automatic logic own_hit(input logic [7:0] rx, input logic [7:0] adr);
		own_hit = (rx[7:1] == adr[7:1]);
	endfunction

	function automatic logic gc_hit(input logic [7:0] rx, input logic [7:0] adr);
		gc_hit = (rx[7:1] == tws_pkg::GC_ADDR) && adr[0];
	endfunction

	// pin synchronisers
	logic [1:0] scl_sy;
	logic [1:0] sda_sy;
	logic scl_q;
	logic sda_q;

	// registers
	logic [7:0] own_slave_address;
	tws_pkg::tws_ctrl_t ctrl;
	logic [7:0] bus_data_byte;
	logic [7:0] status_code;
	logic [1:0] prescale;

	// engine
	tws_pkg::tws_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic [7:0] tx_sh;
	logic [9:0] start_cnt;
	logic ack_drive;
	logic master_drive;
	logic loaded;
	logic last_byte;
	logic acked;
	logic nack;
	logic rd_dir;
	logic gc_mode;
	logic arb_lost;
	logic busy;
	logic hold;
	logic wake;
	logic flag_q;
	logic ev_set;
	logic [7:0] ev_code;
	logic rx_load;
	logic sta_done;

	wire logic scl = scl_sy[1];
	wire logic sda = sda_sy[1];
	wire logic scl_rise = scl & ~scl_q;
	wire logic scl_fall = ~scl & scl_q;
	wire logic start_det = scl & scl_q & sda_q & ~sda;
	wire logic stop_det = scl & scl_q & ~sda_q & sda;
	wire logic flag_fell = flag_q & ~ctrl.interrupt_flag;

	wire logic addressed = (state == tws_pkg::ST_RX) || (state == tws_pkg::ST_RX_ACK) ||
		(state == tws_pkg::ST_TX) || (state == tws_pkg::ST_TX_ACK);
	wire logic is_own = own_hit(shreg, own_slave_address);
	wire logic is_gc = gc_hit(shreg, own_slave_address);
	wire logic addr_match = ctrl.acknowledge_enable & (is_own | is_gc); // R5 R6 R7 R14
	wire logic bus_free_start = ctrl.start_request & ~busy & ~ctrl.interrupt_flag;
	wire logic tx_drive = (state == tws_pkg::ST_TX) & loaded & ~tx_sh[7];

	// apb decode
	wire logic acc = PSEL & PENABLE;
	wire logic wr = acc & PWRITE;
	wire logic sel_addr = (PADDR == tws_pkg::OFS_ADDR);
	wire logic sel_ctrl = (PADDR == tws_pkg::OFS_CTRL);
	wire logic sel_stat = (PADDR == tws_pkg::OFS_STAT);
	wire logic sel_data = (PADDR == tws_pkg::OFS_DATA);
	wire logic hit = sel_addr | sel_ctrl | sel_stat | sel_data;
	wire tws_pkg::tws_ctrl_t wd = tws_pkg::tws_ctrl_t'(PWDATA[7:0]);
	wire logic clr_req = wr & sel_ctrl & wd.interrupt_flag;
	wire logic [7:0] code_view = ctrl.interrupt_flag ? status_code : tws_pkg::SC_NONE; // R21
	wire logic [7:0] stat_view = {code_view[7:tws_pkg::STAT_CODE_LSB], 1'b0, prescale}; // R18
	wire logic [7:0] rd_byte = sel_addr ? own_slave_address :
		sel_ctrl ? ctrl :
		sel_stat ? stat_view :
		sel_data ? bus_data_byte : 8'h00;

	assign PRDATA = {24'h000000, rd_byte};
	assign PREADY = 1'b1;
	assign PSLVERR = acc & ~hit;

	// open-drain pins only ever pull low
	assign SCL_OUT = 1'b0;
	assign SDA_OUT = 1'b0;
	assign SCL_OE = hold & ctrl.interrupt_flag; // R16 R22
	assign SDA_OE = ack_drive | tx_drive | master_drive; // R13
	assign WAKE = wake;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			scl_sy <= 2'h3;
			sda_sy <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else if (CE) begin
			scl_sy <= {scl_sy[0], SCL_IN};
			sda_sy <= {sda_sy[0], SDA_IN};
			scl_q <= scl_sy[1];
			sda_q <= sda_sy[1];
		end
	end

	// own address, data and status registers
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			own_slave_address <= tws_pkg::ADDR_RST;
			bus_data_byte <= tws_pkg::DATA_RST;
			status_code <= tws_pkg::SC_NONE;
			prescale <= tws_pkg::PRE_RST;
		end else if (CE) begin
			if (wr & sel_addr)
				own_slave_address <= PWDATA[7:0];
			if (wr & sel_stat)
				prescale <= PWDATA[tws_pkg::STAT_PRE_W-1:0];
			if (rx_load)
				bus_data_byte <= shreg;
			else if (wr & sel_data & ctrl.interrupt_flag)
				bus_data_byte <= PWDATA[7:0];
			if (ev_set)
				status_code <= ev_code; // R10
		end
	end

	// control register; a hardware set wins over a software clear
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			ctrl <= tws_pkg::tws_ctrl_t'(tws_pkg::CTRL_RST);
		end else if (CE) begin
			if (wr & sel_ctrl) begin
				ctrl.acknowledge_enable <= wd.acknowledge_enable;
				ctrl.start_request <= wd.start_request;
				ctrl.stop_request <= wd.stop_request;
				ctrl.interface_enable <= wd.interface_enable;
				ctrl.interrupt_enable <= wd.interrupt_enable;
			end else begin
				if (sta_done)
					ctrl.start_request <= 1'b0;
				if (ctrl.stop_request)
					ctrl.stop_request <= 1'b0;
			end
			if (ev_set)
				ctrl.interrupt_flag <= 1'b1;
			else if (clr_req)
				ctrl.interrupt_flag <= 1'b0; // R16
			if (wr & sel_data)
				ctrl.write_collision_flag <= ~ctrl.interrupt_flag;
		end
	end

	// bus engine
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state <= tws_pkg::ST_IDLE;
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
			tx_sh <= 8'hff;
			start_cnt <= 10'h000;
			ack_drive <= 1'b0;
			master_drive <= 1'b0;
			loaded <= 1'b0;
			last_byte <= 1'b0;
			acked <= 1'b0;
			nack <= 1'b0;
			rd_dir <= 1'b0;
			gc_mode <= 1'b0;
			arb_lost <= 1'b0;
			busy <= 1'b0;
			hold <= 1'b0;
			wake <= 1'b0;
			flag_q <= 1'b0;
			ev_set <= 1'b0;
			ev_code <= tws_pkg::SC_NONE;
			rx_load <= 1'b0;
			sta_done <= 1'b0;
		end else if (CE) begin
			ev_set <= 1'b0;
			rx_load <= 1'b0;
			sta_done <= 1'b0;
			flag_q <= ctrl.interrupt_flag;
			if (start_det)
				busy <= 1'b1;
			else if (stop_det)
				busy <= 1'b0;
			if (~SLEEP_DEEP)
				wake <= 1'b0;
			if (clr_req & ~ev_set)
				hold <= 1'b0;
			if (~ctrl.interface_enable | ctrl.stop_request) begin
				state <= tws_pkg::ST_IDLE;
				ack_drive <= 1'b0;
				master_drive <= 1'b0;
				hold <= 1'b0;
				loaded <= 1'b0;
			end else if ((start_det | stop_det) && state != tws_pkg::ST_MSTART) begin
				if (addressed) begin
					ev_set <= 1'b1; // R3
					ev_code <= tws_pkg::SC_STOP;
				end
				if (start_det & ctrl.start_request)
					arb_lost <= 1'b1;
				else if (stop_det)
					arb_lost <= 1'b0;
				state <= start_det ? tws_pkg::ST_ADDR : tws_pkg::ST_IDLE; // R3
				bit_cnt <= 4'h0;
				ack_drive <= 1'b0;
				loaded <= 1'b0;
				hold <= 1'b0;
			end else begin
				unique case (state)
				tws_pkg::ST_IDLE, tws_pkg::ST_IGNORE: begin
					if (bus_free_start) begin
						state <= tws_pkg::ST_MSTART; // R4
						master_drive <= 1'b1;
						start_cnt <= 10'h000;
						arb_lost <= 1'b0;
					end
				end
				tws_pkg::ST_MSTART: begin
					if (flag_fell) begin
						state <= tws_pkg::ST_IDLE;
						master_drive <= 1'b0;
					end else if (start_cnt < 10'(tws_pkg::START_HOLD_CYC)) begin
						start_cnt <= start_cnt + 10'h001;
					end else if (start_cnt == 10'(tws_pkg::START_HOLD_CYC)) begin
						start_cnt <= start_cnt + 10'h001;
						ev_set <= 1'b1;
						ev_code <= tws_pkg::SC_START;
						sta_done <= 1'b1;
					end
				end
				tws_pkg::ST_ADDR: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == tws_pkg::BITS_PER_BYTE) begin
						if (addr_match) begin
							ack_drive <= 1'b1; // R5 R15
							rd_dir <= shreg[0];
							gc_mode <= ~is_own;
							state <= tws_pkg::ST_ADDR_ACK;
							if (SLEEP_DEEP)
								wake <= 1'b1; // R15
						end else begin
							state <= tws_pkg::ST_IGNORE; // R14
						end
					end
				end
				tws_pkg::ST_ADDR_ACK: begin
					if (scl_fall) begin
						ack_drive <= 1'b0;
						ev_set <= 1'b1; // R10
						hold <= 1'b1; // R16 R22
						bit_cnt <= 4'h0;
						loaded <= 1'b0;
						arb_lost <= 1'b0;
						if (rd_dir) begin
							state <= tws_pkg::ST_TX; // R9
							ev_code <= arb_lost ? tws_pkg::SC_ARB_SLA_R : tws_pkg::SC_SLA_R; // R11
						end else begin
							state <= tws_pkg::ST_RX; // R9
							if (gc_mode)
								ev_code <= arb_lost ? tws_pkg::SC_ARB_GC : tws_pkg::SC_GC;
							else
								ev_code <= arb_lost ? tws_pkg::SC_ARB_SLA_W : tws_pkg::SC_SLA_W;
						end
					end
				end
				tws_pkg::ST_RX: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (scl_fall && bit_cnt == tws_pkg::BITS_PER_BYTE) begin
						ack_drive <= ctrl.acknowledge_enable; // R1
						acked <= ctrl.acknowledge_enable;
						rx_load <= ~SLEEP_DEEP; // R17
						state <= tws_pkg::ST_RX_ACK;
					end
				end
				tws_pkg::ST_RX_ACK: begin
					if (scl_fall) begin
						ack_drive <= 1'b0;
						ev_set <= 1'b1;
						hold <= 1'b1; // R22
						bit_cnt <= 4'h0;
						if (gc_mode)
							ev_code <= acked ? tws_pkg::SC_GC_RX_ACK : tws_pkg::SC_GC_RX_NACK;
						else
							ev_code <= acked ? tws_pkg::SC_RX_ACK : tws_pkg::SC_RX_NACK;
						state <= acked ? tws_pkg::ST_RX : tws_pkg::ST_IGNORE; // R1 R2
					end
				end
				tws_pkg::ST_TX: begin
					if (~loaded) begin
						if (flag_fell) begin
							tx_sh <= bus_data_byte; // R19 R20
							last_byte <= ~ctrl.acknowledge_enable; // R12
							loaded <= 1'b1;
						end
					end else if (scl_fall) begin
						if (bit_cnt == tws_pkg::BITS_PER_BYTE - 4'h1) begin
							state <= tws_pkg::ST_TX_ACK;
							loaded <= 1'b0;
						end else begin
							tx_sh <= {tx_sh[6:0], 1'b1};
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				tws_pkg::ST_TX_ACK: begin
					if (scl_rise) begin
						nack <= sda;
					end else if (scl_fall) begin
						ev_set <= 1'b1;
						bit_cnt <= 4'h0;
						if (nack) begin
							ev_code <= tws_pkg::SC_TX_NACK; // R12
							state <= tws_pkg::ST_IGNORE;
						end else if (last_byte) begin
							ev_code <= tws_pkg::SC_TX_LAST_ACK; // R12
							state <= tws_pkg::ST_IGNORE; // R13
						end else begin
							ev_code <= tws_pkg::SC_TX_ACK; // R20
							state <= tws_pkg::ST_TX;
							hold <= 1'b1; // R22
						end
					end
				end
				endcase
			end
		end
	end

endmodule // tws_slave

`default_nettype wire

// [sim/tb_top.sv]
// self-checking bench for the two-wire slave
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam logic [31:0] RUN = 32'h44;
	localparam logic [31:0] GO = 32'hc4;
	localparam logic [31:0] LAST = 32'h84;
	// clears the flag and keeps a start request pending
	localparam logic [31:0] RESTART = 32'he4;
	localparam logic [31:0] PRE = 32'h03;
	logic clk, rst, psel, pen, pwr, sleep, pready, pslverr, scl_oe, sda_oe, m_scl, m_sda, wake;
	logic [7:0] paddr, q;
	logic [31:0] pwdata, prdata, rdv;
	logic k;
	int error_cnt = 0;
	int num_checks = 0;
	wire scl = !(scl_oe || m_scl);
	wire sda = !(sda_oe || m_sda);
	tws_slave i_tws_slave (.CLOCK(clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .SCL_IN(scl), .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda),
		.SDA_OUT(), .SDA_OE(sda_oe), .SLEEP_DEEP(sleep), .WAKE(wake));
	tws_master i_tws_master (.scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rdv = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic xb(input logic [7:0] d, input logic a);
		i_tws_master.xfer(d, a, q, k);
	endtask
	// polls the flag, then reads the status code
	task automatic stat(input logic [7:0] e);
		int n;
		n = 0;
		do
			apb(1'b0, tws_pkg::OFS_CTRL, 32'h0);
		while (rdv[7] !== 1'b1 && ++n < 400);
		apb(1'b0, tws_pkg::OFS_STAT, 32'h0);
		chk(rdv & 32'hf8, {24'h0, e});
	endtask
	task automatic t_reset();
		apb(1'b0, tws_pkg::OFS_ADDR, 32'h0);
		chk(rdv, {24'h0, tws_pkg::ADDR_RST});
		apb(1'b0, tws_pkg::OFS_STAT, 32'h0);
		chk(rdv, {24'h0, tws_pkg::SC_NONE});
		apb(1'b1, tws_pkg::OFS_STAT, PRE);
		apb(1'b0, tws_pkg::OFS_STAT, 32'h0);
		chk(rdv, {24'h0, tws_pkg::SC_NONE} | PRE);
		apb(1'b0, 8'h10, 32'h0);
		chk(rdv, 32'h0);
		apb(1'b1, tws_pkg::OFS_ADDR, 32'h53);
		apb(1'b1, tws_pkg::OFS_CTRL, RUN);
	endtask
	task automatic t_write();
		i_tws_master.start();
		xb(8'h52, 1'b1);
		chk({31'h0, k}, 32'h0);
		stat(tws_pkg::SC_SLA_W);
		apb(1'b1, tws_pkg::OFS_CTRL, GO);
		xb(8'ha5, 1'b1);
		stat(tws_pkg::SC_RX_ACK);
		apb(1'b0, tws_pkg::OFS_DATA, 32'h0);
		chk(rdv, 32'ha5);
		apb(1'b1, tws_pkg::OFS_CTRL, GO);
		i_tws_master.stop();
		stat(tws_pkg::SC_STOP);
		apb(1'b1, tws_pkg::OFS_CTRL, GO);
	endtask
	task automatic t_gcall();
		i_tws_master.start();
		xb(8'h00, 1'b1);
		stat(tws_pkg::SC_GC);
		apb(1'b1, tws_pkg::OFS_CTRL, GO);
		xb(8'h3c, 1'b1);
		stat(tws_pkg::SC_GC_RX_ACK);
		apb(1'b1, tws_pkg::OFS_CTRL, LAST);
		xb(8'hc3, 1'b1);
		chk({31'h0, k}, 32'h1);
		stat(tws_pkg::SC_GC_RX_NACK);
		apb(1'b1, tws_pkg::OFS_CTRL, GO);
		xb(8'h11, 1'b1);
		chk({31'h0, k}, 32'h1);
		i_tws_master.stop();
		apb(1'b1, tws_pkg::OFS_ADDR, 32'h52);
		i_tws_master.start();
		xb(8'h00, 1'b1);
		chk({31'h0, k}, 32'h1);
		i_tws_master.stop();
		apb(1'b1, tws_pkg::OFS_ADDR, 32'h53);
	endtask
	task automatic t_isolate_wake();
		apb(1'b1, tws_pkg::OFS_CTRL, 32'h04);
		i_tws_master.start();
		xb(8'h52, 1'b1);
		chk({31'h0, k}, 32'h1);
		i_tws_master.stop();
		apb(1'b1, tws_pkg::OFS_CTRL, RUN);
		sleep <= 1'b1;
		i_tws_master.start();
		xb(8'h52, 1'b1);
		stat(tws_pkg::SC_SLA_W);
		chk({30'h0, wake, scl_oe}, 32'h3);
		apb(1'b1, tws_pkg::OFS_CTRL, GO);
		sleep <= 1'b0;
		apb(1'b0, tws_pkg::OFS_STAT, 32'h0);
		chk({23'h0, scl_oe, rdv[7:0]}, {24'h0, tws_pkg::SC_NONE} | PRE);
		i_tws_master.stop();
		stat(tws_pkg::SC_STOP);
		apb(1'b1, tws_pkg::OFS_CTRL, GO);
	endtask
	task automatic t_read();
		i_tws_master.start();
		xb(8'h53, 1'b1);
		stat(tws_pkg::SC_SLA_R);
		apb(1'b1, tws_pkg::OFS_DATA, 32'h96);
		apb(1'b1, tws_pkg::OFS_CTRL, GO);
		xb(8'hff, 1'b0);
		chk({24'h0, q}, 32'h96);
		stat(tws_pkg::SC_TX_ACK);
		apb(1'b1, tws_pkg::OFS_DATA, 32'h5a);
		apb(1'b1, tws_pkg::OFS_CTRL, LAST);
		xb(8'hff, 1'b0);
		chk({24'h0, q}, 32'h5a);
		stat(tws_pkg::SC_TX_LAST_ACK);
		apb(1'b1, tws_pkg::OFS_CTRL, GO);
		xb(8'hff, 1'b1);
		chk({24'h0, q}, 32'hff);
		// foreign start while our start request waits on a busy bus
		apb(1'b1, tws_pkg::OFS_CTRL, RESTART);
		i_tws_master.start();
		xb(8'h53, 1'b1);
		stat(tws_pkg::SC_ARB_SLA_R);
		apb(1'b1, tws_pkg::OFS_DATA, 32'h0f);
		apb(1'b1, tws_pkg::OFS_CTRL, RESTART);
		xb(8'hff, 1'b1);
		chk({24'h0, q}, 32'h0f);
		stat(tws_pkg::SC_TX_NACK);
		apb(1'b1, tws_pkg::OFS_CTRL, RESTART);
		i_tws_master.stop();
		stat(tws_pkg::SC_START);
		apb(1'b1, tws_pkg::OFS_CTRL, GO);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// the tests need about 12 us
	initial begin
		#300us;
		error_cnt++;
		wrap_up();
	end
	initial begin
		{rst, psel, pen, pwr, sleep, paddr, pwdata} = {1'b1, 44'h0};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_write();
		t_gcall();
		t_isolate_wake();
		t_read();
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire

// [sim/tws_master.sv]
// bus master model on the open-drain lines
`timescale 1ns/1ps
`default_nettype none
module tws_master (
	// resolved lines
	input wire logic scl,
	input wire logic sda,
	// pull-low enables
	output logic scl_oe,
	output logic sda_oe
);
	// quarter of the 48 ns serial clock period
	localparam time Q = 12;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	task automatic start();
		sda_oe = 1'b0;
		#Q scl_oe = 1'b0;
		wait (scl === 1'b1);
		#Q sda_oe = 1'b1;
		#Q scl_oe = 1'b1;
	endtask
	// waits out clock stretching before sampling
	task automatic bit_io(input logic b, output logic r);
		#Q sda_oe = !b;
		#Q scl_oe = 1'b0;
		wait (scl === 1'b1);
		#Q r = sda;
		#Q scl_oe = 1'b1;
	endtask
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(a, k);
	endtask
	task automatic stop();
		#Q sda_oe = 1'b1;
		#Q scl_oe = 1'b0;
		wait (scl === 1'b1);
		#Q sda_oe = 1'b0;
	endtask
endmodule // tws_master
`default_nettype wire

// [sim/tws_slave_monitor.sv]
// port checker for the two-wire slave
`timescale 1ns/1ps
`default_nettype none
module tws_slave_monitor (
	// clock, reset, enable
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	// register bus
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// lines and power
	input wire logic SCL_OUT,
	input wire logic SCL_OE,
	input wire logic SDA_OUT,
	input wire logic SDA_OE,
	input wire logic SLEEP_DEEP,
	input wire logic WAKE
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);
	wire acc = PSEL && PENABLE;
	wire rd = acc && !PWRITE;
	wire map = PADDR < 8'h10 && PADDR[1:0] == 2'h0;
	wire ctl_wr = acc && PWRITE && PADDR == tws_pkg::OFS_CTRL;
	wire st_rd = rd && PADDR == tws_pkg::OFS_STAT;
	wire [7:0] code = PRDATA[7:0] & 8'hf8;
	logic [7:0] own;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST)
			own <= tws_pkg::ADDR_RST;
		else if (CE && acc && PWRITE && PADDR == tws_pkg::OFS_ADDR)
			own <= PWDATA[7:0];
	end
	sequence s_woke;
		$rose(WAKE);
	endsequence
	a_ready_err: assert property (acc |-> PREADY && PSLVERR == !map)
		else $error("ready or error flag wrong");
	a_unmapped_zero: assert property (rd && !map |-> PRDATA == 32'h0)
		else $error("unmapped read not zero");
	a_addr_readback: assert property (rd && PADDR == tws_pkg::OFS_ADDR |-> PRDATA == {24'h0, own})
		else $error("address register lost");
	a_lines_low: assert property (SCL_OUT == 1'b0 && SDA_OUT == 1'b0)
		else $error("line driven high");
	a_hold_scl: assert property (SCL_OE && !ctl_wr |=> SCL_OE)
		else $error("clock released early");
	a_stretch_code: assert property (st_rd && code inside {8'h60, 8'h70, 8'h80, 8'h90, 8'ha8, 8'hb8} |-> SCL_OE)
		else $error("no stretch in slave state");
	a_wake_clear: assert property (!SLEEP_DEEP |=> !WAKE)
		else $error("wake without sleep");
	a_wake_stretch: assert property (s_woke |-> ##[0:60] SCL_OE)
		else $error("no clock hold after wake");
	a_last_free: assert property (st_rd && code inside {8'hc0, 8'hc8} |-> !SDA_OE)
		else $error("data driven after last byte");
endmodule // tws_slave_monitor
bind tws_slave tws_slave_monitor i_tws_slave_monitor (.CLOCK, .RST, .CE, .PSEL, .PENABLE,
	.PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SCL_OUT, .SCL_OE, .SDA_OUT,
	.SDA_OE, .SLEEP_DEEP, .WAKE);
`default_nettype wire
